// [src/ccp_top.v]
// Camera capture front end and preview path with an APB register slave.
`timescale 1ns/1ps
`include "ccp_map.vh"

module ccp_top (
    // Clock and reset.
    input wire i_clk,
    input wire i_arst_n,
    // APB slave.
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Sensor pins.
    input wire i_sensor_pixel_clock,
    input wire i_frame_sync_in,
    input wire i_line_sync_in,
    input wire [11:0] i_pix_data,
    output reg o_sensor_master_clock_out,
    // Formatted memory words.
    output reg [31:0] o_word,
    output reg o_word_valid
);

    // Reverse the bit order of a byte.
    function [7:0] ccp_rev8;
        input [7:0] b;
        integer k;
        begin
            ccp_rev8 = 8'h00;
            for (k = 0; k < 8; k = k + 1)
                ccp_rev8[k] = b[7 - k];
        end
    endfunction

    // True for every implemented register offset.
    function ccp_mapped;
        input [7:0] a;
        begin
            ccp_mapped = (a == `CCP_ADDR_CTRL) || (a == `CCP_ADDR_TIMING) || (a == `CCP_ADDR_DECIM) ||
                         (a == `CCP_ADDR_CSC0) || (a == `CCP_ADDR_CSC1) || (a == `CCP_ADDR_STATUS) ||
                         (a == `CCP_ADDR_DATA);
        end
    endfunction

    reg [31:0] ctrl;
    reg [31:0] timing;
    reg [6:0] decim;
    reg [31:0] csc0;
    reg [31:0] csc1;
    reg [7:0] frame_cnt;
    reg [15:0] word_cnt;
    reg in_frame;
    reg act;
    reg [31:0] rd_mux;

    wire en = ctrl[`CCP_CTRL_EN];
    wire emb = ctrl[`CCP_CTRL_EMB];
    wire [1:0] fmt = ctrl[`CCP_CTRL_FMT_LSB + 1:`CCP_CTRL_FMT_LSB];
    wire [1:0] yord = ctrl[`CCP_CTRL_YORD_LSB + 1:`CCP_CTRL_YORD_LSB];
    wire [1:0] rgbl = ctrl[`CCP_CTRL_RGBL_LSB + 1:`CCP_CTRL_RGBL_LSB];
    wire gray = (fmt == `CCP_FMT_GRAY);
    wire [7:0] line_start_pixel_delay = timing[7:0];
    wire [7:0] frame_start_blank_lines = timing[15:8];

    // Register read view; status shows the capture state.
    always @* begin
        case (i_paddr)
            `CCP_ADDR_CTRL: rd_mux = ctrl;
            `CCP_ADDR_TIMING: rd_mux = timing;
            `CCP_ADDR_DECIM: rd_mux = {25'h0000000, decim};
            `CCP_ADDR_CSC0: rd_mux = csc0;
            `CCP_ADDR_CSC1: rd_mux = csc1;
            `CCP_ADDR_STATUS: rd_mux = {word_cnt, frame_cnt, 6'h00, act, in_frame};
            `CCP_ADDR_DATA: rd_mux = o_word;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // APB slave: data and error are prepared in the setup cycle so every output is a flop.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable) begin
            o_pready <= 1'b1;
            o_pslverr <= ~ccp_mapped(i_paddr);
            o_prdata <= i_pwrite ? 32'h00000000 : rd_mux;
        end else begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // Register writes take effect at the access edge; read-only offsets ignore writes.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl <= `CCP_RST_CTRL;
            timing <= `CCP_RST_TIMING;
            decim <= `CCP_RST_DECIM;
            csc0 <= `CCP_RST_CSC0;
            csc1 <= `CCP_RST_CSC1;
        end else if (i_psel && i_penable && o_pready && i_pwrite) begin
            case (i_paddr)
                `CCP_ADDR_CTRL: ctrl <= i_pwdata;
                `CCP_ADDR_TIMING: timing <= i_pwdata;
                `CCP_ADDR_DECIM: decim <= i_pwdata[6:0];
                `CCP_ADDR_CSC0: csc0 <= i_pwdata;
                `CCP_ADDR_CSC1: csc1 <= i_pwdata;
                default: ;
            endcase
        end
    end

    // Sensor master clock, divided from the system clock while enabled.
    reg [2:0] mck_cnt;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mck_cnt <= 3'h0;
            o_sensor_master_clock_out <= 1'b0;
        end else if (!ctrl[`CCP_CTRL_MCK_EN]) begin
            mck_cnt <= 3'h0;
            o_sensor_master_clock_out <= 1'b0;
        end else if (mck_cnt == `CCP_MCK_HALF) begin
            mck_cnt <= 3'h0;
            o_sensor_master_clock_out <= ~o_sensor_master_clock_out;
        end else begin
            mck_cnt <= mck_cnt + 3'h1;
        end
    end

    // Three-stage synchroniser; a bit only changes once stages two and three agree.
    wire [14:0] pin_vec = {i_sensor_pixel_clock, i_frame_sync_in, i_line_sync_in, i_pix_data};
    reg [14:0] s1;
    reg [14:0] s2;
    reg [14:0] s3;
    reg [14:0] flt;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1 <= 15'h0000;
            s2 <= 15'h0000;
            s3 <= 15'h0000;
            flt <= 15'h0000;
        end else begin
            s1 <= pin_vec;
            s2 <= s1;
            s3 <= s2;
            flt <= (flt & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
        end
    end

    // Pixel clock edge detection on the filtered copy; the sensor clock is never a clock here.
    reg pclk_d;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            pclk_d <= 1'b0;
        else
            pclk_d <= flt[14];
    end
    wire ev = en & (ctrl[`CCP_CTRL_PCLK_POL] ? (pclk_d & ~flt[14]) : (~pclk_d & flt[14]));
    wire vs_act = flt[13] ^ ctrl[`CCP_CTRL_VS_POL];
    wire hs_act = flt[12] ^ ctrl[`CCP_CTRL_HS_POL];
    wire [7:0] raw = flt[7:0];
    wire swap_on = ctrl[`CCP_CTRL_SWAP] && (fmt == `CCP_FMT_RGB888 || fmt == `CCP_FMT_RGB565);
    wire [7:0] bsel = swap_on ? ccp_rev8(raw) : raw;

    // Embedded code detection on the raw byte stream.
    reg [7:0] h1;
    reg [7:0] h2;
    reg [7:0] h3;
    wire hit = ({h3, h2, h1} == `CCP_CODE_PRE);
    wire sav = hit && (raw == `CCP_CODE_SAV);
    wire eav = hit && (raw == `CCP_CODE_EAV);
    wire vbc = hit && raw[`CCP_CODE_FBIT] && raw[`CCP_CODE_VBIT];

    // Front end: produces byte pulses and line and frame start pulses in either sync mode.
    reg vs_d;
    reg hs_d;
    reg [7:0] line_cnt;
    reg [7:0] pix_cnt;
    reg [7:0] p1;
    reg [7:0] p2;
    reg [7:0] p3;
    reg [2:0] pv;
    reg vb_seen;
    reg fe_v;
    reg fe_line;
    reg fe_frame;
    reg [11:0] fe_d;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {vs_d, hs_d, in_frame, act, vb_seen, fe_v, fe_line, fe_frame} <= 8'h00;
            {line_cnt, pix_cnt, h1, h2, h3, p1, p2, p3} <= 64'h0000000000000000;
            pv <= 3'h0;
            fe_d <= 12'h000;
        end else begin
            fe_v <= 1'b0;
            fe_line <= 1'b0;
            fe_frame <= 1'b0;
            if (!en) begin
                {in_frame, act, vb_seen} <= 3'h0;
                pv <= 3'h0;
                line_cnt <= 8'h00;
            end else if (ev && emb) begin
                // Sync pins are not looked at; only the low byte is used.
                h1 <= raw;
                h2 <= h1;
                h3 <= h2;
                p1 <= bsel;
                p2 <= p1;
                p3 <= p2;
                fe_d <= {4'h0, p3};
                if (hit) begin
                    // The FF 00 00 prefix still in the pipe is dropped with the code itself.
                    pv <= 3'h0;
                    act <= sav;
                    fe_line <= sav;
                    if (sav && vb_seen) begin
                        // Frame recovery needs a blanking line between frames.
                        fe_frame <= 1'b1;
                        in_frame <= 1'b1;
                        vb_seen <= 1'b0;
                    end else if (vbc) begin
                        vb_seen <= 1'b1;
                        in_frame <= 1'b0;
                    end
                end else begin
                    fe_v <= pv[2];
                    pv <= {pv[1:0], act};
                end
            end else if (ev) begin
                vs_d <= vs_act;
                hs_d <= hs_act;
                fe_d <= {flt[11:8], bsel};
                if (vs_act && !vs_d) begin
                    line_cnt <= 8'h00;
                    in_frame <= 1'b1;
                    fe_frame <= 1'b1;
                end else if (hs_act && !hs_d) begin
                    if (line_cnt != `CCP_SAT8)
                        line_cnt <= line_cnt + 8'h01;
                    fe_line <= (line_cnt >= frame_start_blank_lines);
                end
                if (hs_act)
                    pix_cnt <= 8'h00;
                else if (pix_cnt != `CCP_SAT8)
                    pix_cnt <= pix_cnt + 8'h01;
                fe_v <= in_frame && !hs_act && !vs_act && (line_cnt > frame_start_blank_lines) && (pix_cnt >= line_start_pixel_delay);
                act <= !hs_act && (line_cnt > frame_start_blank_lines);
            end
        end
    end

    // Byte decoding for YCbCr order and RGB 5:6:5 layouts.
    reg [7:0] w0;
    reg [7:0] w1;
    reg [7:0] w2;
    wire [7:0] cur = fe_d[7:0];
    reg [7:0] dy0;
    reg [7:0] dy1;
    reg [7:0] dcb;
    reg [7:0] dcr;
    reg [7:0] r5;
    reg [7:0] g5;
    reg [7:0] b5;
    always @* begin
        case (yord)
            2'h0: {dcb, dy0, dcr, dy1} = {w0, w1, w2, cur};
            2'h1: {dcr, dy0, dcb, dy1} = {w0, w1, w2, cur};
            2'h2: {dy0, dcb, dy1, dcr} = {w0, w1, w2, cur};
            default: {dy0, dcr, dy1, dcb} = {w0, w1, w2, cur};
        endcase
        if (rgbl == `CCP_RGBL_MODE2) begin
            r5 = {w0[4:0], 3'h0};
            g5 = {cur[2:0], w0[7:5], 2'h0};
            b5 = {cur[7:3], 3'h0};
        end else begin
            r5 = {w0[7:3], 3'h0};
            g5 = {w0[2:0], cur[7:5], 2'h0};
            b5 = {cur[4:0], 3'h0};
        end
    end

    // Assembler: gathers bytes into pixels; the second YCbCr pixel follows one cycle later.
    reg [1:0] ph;
    reg pend;
    reg [7:0] py1;
    reg asm_v;
    reg asm_ycc;
    reg [7:0] ca;
    reg [7:0] cb;
    reg [7:0] cc;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {ph, pend, asm_v, asm_ycc} <= 5'h00;
            {w0, w1, w2, py1, ca, cb, cc} <= 56'h00000000000000;
        end else begin
            asm_v <= 1'b0;
            if (fe_line || fe_frame) begin
                ph <= 2'h0;
                pend <= 1'b0;
            end else if (pend) begin
                asm_v <= 1'b1;
                ca <= py1;
                pend <= 1'b0;
            end else if (fe_v && !gray) begin
                // Pixel events are far apart because the system clock is the faster one.
                case (ph)
                    2'h0: w0 <= cur;
                    2'h1: w1 <= cur;
                    default: w2 <= cur;
                endcase
                ph <= ph + 2'h1;
                asm_ycc <= (fmt == `CCP_FMT_YCC);
                if (fmt == `CCP_FMT_YCC && ph == 2'h3) begin
                    {asm_v, pend, ca, cb, cc, py1} <= {2'h3, dy0, dcb, dcr, dy1};
                end else if (fmt == `CCP_FMT_RGB888 && ph == 2'h2) begin
                    {asm_v, ca, cb, cc} <= {1'b1, w0, w1, cur};
                    ph <= 2'h0;
                end else if (fmt == `CCP_FMT_RGB565 && ph == 2'h1) begin
                    {asm_v, ca, cb, cc} <= {1'b1, r5, g5, b5};
                    ph <= 2'h0;
                end
            end
        end
    end

    // Fractional decimation in sixteenths; forbidden values below unity act as unity.
    wire [7:0] dec_eff = ({1'b0, decim} < `CCP_DEC_UNITY) ? `CCP_DEC_UNITY : {1'b0, decim};
    reg [7:0] hacc;
    reg [7:0] vacc;
    reg line_keep;
    reg dv;
    reg dycc;
    reg [7:0] da;
    reg [7:0] db;
    reg [7:0] dc;
    wire [7:0] vbase = fe_frame ? 8'h00 : vacc;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {hacc, vacc, da, db, dc} <= 40'h0000000000;
            {line_keep, dv, dycc} <= 3'h0;
        end else begin
            dv <= 1'b0;
            if (fe_line) begin
                // Same ratio vertically: a line is kept when the accumulator is below unity.
                hacc <= 8'h00;
                line_keep <= (vbase < `CCP_DEC_UNITY);
                vacc <= (vbase < `CCP_DEC_UNITY) ? vbase + dec_eff - `CCP_DEC_UNITY
                                                 : vbase - `CCP_DEC_UNITY;
            end else if (fe_frame) begin
                vacc <= 8'h00;
                line_keep <= 1'b0;
                hacc <= 8'h00;
            end else if (asm_v) begin
                // Only dropping is possible, so the image never grows.
                dv <= line_keep && (hacc < `CCP_DEC_UNITY);
                hacc <= (hacc < `CCP_DEC_UNITY) ? hacc + dec_eff - `CCP_DEC_UNITY
                                                : hacc - `CCP_DEC_UNITY;
                {dycc, da, db, dc} <= {asm_ycc, ca, cb, cc};
            end
        end
    end

    // Colour conversion for YCbCr pixels; RGB input passes through.
    wire [7:0] cr_o;
    wire [7:0] cg_o;
    wire [7:0] cb_o;
    ccp_csc u_csc (
        .i_y(da),
        .i_cb(db),
        .i_cr(dc),
        .i_c0(csc0[7:0]),
        .i_c1(csc0[15:8]),
        .i_c2(csc0[23:16]),
        .i_c3(csc0[31:24]),
        .i_c4(csc1[7:0]),
        .i_yoff(csc1[15:8]),
        .i_cboff(csc1[23:16]),
        .i_croff(csc1[31:24]),
        .o_r(cr_o),
        .o_g(cg_o),
        .o_b(cb_o)
    );
    reg cv;
    reg [7:0] pr;
    reg [7:0] pg;
    reg [7:0] pb;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cv <= 1'b0;
            {pr, pg, pb} <= 24'h000000;
        end else begin
            cv <= dv;
            if (dv)
                {pr, pg, pb} <= dycc ? {cr_o, cg_o, cb_o} : {da, db, dc};
        end
    end

    // Formatter: upper bits of each channel, gray samples raw with four zero bits.
    wire hv = gray ? fe_v : cv;
    wire [15:0] half = gray ? {fe_d, 4'h0} : {1'b0, pr[7:3], pg[7:3], pb[7:3]};
    reg hf;
    reg [15:0] first;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {hf, o_word_valid} <= 2'h0;
            first <= 16'h0000;
            o_word <= 32'h00000000;
            word_cnt <= 16'h0000;
            frame_cnt <= 8'h00;
        end else begin
            o_word_valid <= 1'b0;
            if (fe_frame) begin
                hf <= 1'b0;
                word_cnt <= 16'h0000;
                frame_cnt <= frame_cnt + 8'h01;
            end else if (hv) begin
                if (gray && ctrl[`CCP_CTRL_GPPW]) begin
                    o_word <= {half, 16'h0000};
                    o_word_valid <= 1'b1;
                    word_cnt <= word_cnt + 16'h0001;
                end else if (!hf) begin
                    first <= half;
                    hf <= 1'b1;
                end else begin
                    o_word <= {first, half};
                    o_word_valid <= 1'b1;
                    word_cnt <= word_cnt + 16'h0001;
                    hf <= 1'b0;
                end
            end
        end
    end

endmodule

// [src/ccp_map.vh]
// Register offsets, field positions, reset values and codes of the camera capture preview path.
// Operation
// - Sync-pin mode captures on active pixel edge after blank lines and pixel delay.
// - Embedded mode recognises start-of-active-video code FF 00 00 80.
// - Embedded mode recognises end-of-active-video code FF 00 00 9D.
// - Embedded mode stores only bytes between codes; blanking data is discarded.
// - Embedded mode uses an 8-bit path and ignores line and frame sync pins.
// - YCbCr 4:2:2 bytes accepted in one of four selectable component orders.
// - Default RGB layout: 8:8:8 one colour per byte, 5:6:5 R then G then B.
// - RGB layout mode 2 takes 5:6:5 as G low/R then B/G high.
// - Bit swap in default RGB layout reverses each input byte's bit order.
// - RGB 5:6:5 input is converted to RGB 5:5:5 output.
// - Resizer only reduces, one common ratio both directions, fractional decimation.
// - Decimation factor is value over 16; values 0 to 15 are forbidden.
// - RGB computed from offset Y, Cb, Cr with programmable coefficients C0 to C4.
// - Every converted sample is clipped to its range, never wrapped.
// - Formatter packs RGB 5:5:5 keeping upper bits of each channel.
// - Gray packing: two pixels per word or one with low half zero.
// - Gray samples are stored 12-bit with no colour processing.
// - Pixel clock polarity 0 samples on rising edge, 1 on falling edge.
// - Line and frame sync active polarities are selectable independently.
`ifndef CCP_MAP_VH
`define CCP_MAP_VH

`define CCP_ADDR_CTRL 8'h00
`define CCP_ADDR_TIMING 8'h04
`define CCP_ADDR_DECIM 8'h08
`define CCP_ADDR_CSC0 8'h0C
`define CCP_ADDR_CSC1 8'h10
`define CCP_ADDR_STATUS 8'h14
`define CCP_ADDR_DATA 8'h18

`define CCP_CTRL_EN 0
`define CCP_CTRL_EMB 1
`define CCP_CTRL_PCLK_POL 2
`define CCP_CTRL_HS_POL 3
`define CCP_CTRL_VS_POL 4
`define CCP_CTRL_YORD_LSB 5
`define CCP_CTRL_RGBL_LSB 7
`define CCP_CTRL_SWAP 9
`define CCP_CTRL_FMT_LSB 10
`define CCP_CTRL_GPPW 12
`define CCP_CTRL_MCK_EN 13

`define CCP_FMT_YCC 2'h0
`define CCP_FMT_RGB888 2'h1
`define CCP_FMT_RGB565 2'h2
`define CCP_FMT_GRAY 2'h3
`define CCP_RGBL_MODE2 2'h2

`define CCP_RST_CTRL 32'h00000000
`define CCP_RST_TIMING 32'h00000000
`define CCP_RST_DECIM 7'h10
`define CCP_RST_CSC0 32'h1A0D3325
`define CCP_RST_CSC1 32'h80801043

`define CCP_CODE_PRE 24'hFF0000
`define CCP_CODE_SAV 8'h80
`define CCP_CODE_EAV 8'h9D
`define CCP_CODE_VBIT 5
`define CCP_CODE_FBIT 7

`define CCP_DEC_UNITY 8'h10
`define CCP_CSC_FRAC 5
`define CCP_SAT8 8'hFF
`define CCP_MCK_HALF 3'h3

`endif

// [src/ccp_csc.v]
// Colour space converter from offset-corrected YCbCr to clipped 8-bit RGB.
`timescale 1ns/1ps
`include "ccp_map.vh"

module ccp_csc (
    // Pixel components.
    input wire [7:0] i_y,
    input wire [7:0] i_cb,
    input wire [7:0] i_cr,
    // Coefficients with five fraction bits, and offsets.
    input wire [7:0] i_c0,
    input wire [7:0] i_c1,
    input wire [7:0] i_c2,
    input wire [7:0] i_c3,
    input wire [7:0] i_c4,
    input wire [7:0] i_yoff,
    input wire [7:0] i_cboff,
    input wire [7:0] i_croff,
    // Converted colour.
    output wire [7:0] o_r,
    output wire [7:0] o_g,
    output wire [7:0] o_b
);

    // Saturate a scaled sum into 0..255 so overflow never wraps round.
    function [7:0] ccp_clip;
        input signed [20:0] v;
        reg signed [20:0] s;
        begin
            s = v >>> `CCP_CSC_FRAC;
            if (s < 0)
                ccp_clip = 8'h00;
            else if (s > $signed({13'h0000, `CCP_SAT8}))
                ccp_clip = `CCP_SAT8;
            else
                ccp_clip = s[7:0];
        end
    endfunction

    // Offset correction gives signed ten-bit differences.
    wire signed [9:0] yd = $signed({2'b00, i_y}) - $signed({2'b00, i_yoff});
    wire signed [9:0] cbd = $signed({2'b00, i_cb}) - $signed({2'b00, i_cboff});
    wire signed [9:0] crd = $signed({2'b00, i_cr}) - $signed({2'b00, i_croff});

    // Products are exact at nineteen bits, so no precision is lost before clipping.
    wire signed [18:0] p0 = yd * $signed({1'b0, i_c0});
    wire signed [18:0] p1 = crd * $signed({1'b0, i_c1});
    wire signed [18:0] p2 = cbd * $signed({1'b0, i_c2});
    wire signed [18:0] p3 = crd * $signed({1'b0, i_c3});
    wire signed [18:0] p4 = cbd * $signed({1'b0, i_c4});

    // Matrix sums, sign extended before adding.
    wire signed [20:0] rs = {{2{p0[18]}}, p0} + {{2{p1[18]}}, p1};
    wire signed [20:0] gs = {{2{p0[18]}}, p0} - {{2{p2[18]}}, p2} - {{2{p3[18]}}, p3};
    wire signed [20:0] bs = {{2{p0[18]}}, p0} + {{2{p4[18]}}, p4};

    // Each sample is clipped independently.
    assign o_r = ccp_clip(rs);
    assign o_g = ccp_clip(gs);
    assign o_b = ccp_clip(bs);

endmodule

// [verification/ccp_sva.sv]
// Checker of bus answer, word strobe and master clock timing.
`timescale 1ns/1ps
module ccp_sva (
    // Watched ports.
    input logic i_clk,
    input logic i_arst_n,
    input logic i_psel,
    input logic i_penable,
    input logic [31:0] o_prdata,
    input logic o_pready,
    input logic o_pslverr,
    input logic o_sensor_master_clock_out,
    input logic [31:0] o_word,
    input logic o_word_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Each master clock level lasts four bus cycles.
    sequence hi_s; o_sensor_master_clock_out [*3] ##1 !o_sensor_master_clock_out; endsequence
    sequence lo_s; !o_sensor_master_clock_out [*3] ##1 o_sensor_master_clock_out; endsequence
    setup_ready_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("ready without setup");
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready held");
    err_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h00000000)
        else $error("error answer malformed");
    word_pulse_a: assert property (o_word_valid |=> !o_word_valid)
        else $error("word strobe held");
    word_hold_a: assert property (!o_word_valid |-> $stable(o_word))
        else $error("word changed without strobe");
    mck_high_a: assert property ($rose(o_sensor_master_clock_out) |=> hi_s)
        else $error("master clock high level wrong");
    mck_low_a: assert property ($fell(o_sensor_master_clock_out) |=> lo_s)
        else $error("master clock low level wrong");
endmodule
bind ccp_top ccp_sva u_sva (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_sensor_master_clock_out(o_sensor_master_clock_out), .o_word(o_word), .o_word_valid(o_word_valid));

// [verification/ccp_sensor.sv]
// Sensor model driving pixel clock, syncs and data.
`timescale 1ns/1ps
module ccp_sensor (
    // Sensor pins.
    output logic o_pclk,
    output logic o_vs,
    output logic o_hs,
    output logic [11:0] o_d
);
    logic c = 0, vs = 0, hs = 0, pol = 0, vpol = 0, hpol = 0;
    logic [11:0] d = 12'h000;
    // Pins follow the programmed polarities; the clock stands still between transfers.
    assign o_pclk = c ^ pol;
    assign o_vs = vs ^ vpol;
    assign o_hs = hs ^ hpol;
    assign o_d = d;
    // One 125 ns period, data centred on the active edge to give margin on both sides.
    task automatic pix(input logic [11:0] v);
        d = v;
        #62.5 c = 1;
        #62.5 c = 0;
    endtask
    // Two-period sync pulse; data is inverted in the first period and restored in the second.
    task automatic pulse(input bit f);
        {vs, hs} = f ? 2'b10 : 2'b01;
        pix(~d);
        pix(~d);
        {vs, hs} = 2'b00;
    endtask
    // Reference code: preamble, then the status byte.
    task automatic code(input logic [7:0] s);
        pix(12'h0FF);
        pix(12'h000);
        pix(12'h000);
        pix({4'h0, s});
    endtask
endmodule

// [verification/tb_ccp_top.sv]
// Testbench of the capture preview path over the register bus and sensor pins.
`timescale 1ns/1ps
module tb_ccp_top;
    logic i_clk = 0, i_arst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, e;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h00000000, r;
    logic [31:0] wq[$];
    wire [31:0] o_prdata, o_word;
    wire o_pready, o_pslverr, o_mck, o_word_valid, pclk, vs, hs;
    wire [11:0] pd;
    int err_total = 0, samples_checked = 0;
    ccp_top dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sensor_pixel_clock(pclk), .i_frame_sync_in(vs),
        .i_line_sync_in(hs), .i_pix_data(pd), .o_sensor_master_clock_out(o_mck), .o_word(o_word),
        .o_word_valid(o_word_valid));
    ccp_sensor sen (.o_pclk(pclk), .o_vs(vs), .o_hs(hs), .o_d(pd));
    // Bus clock of 100 MHz.
    always #5 i_clk = ~i_clk;
    // Every strobed word is queued for the frame checks.
    always @(posedge i_clk) if (o_word_valid === 1'b1) wq.push_back(o_word);
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    // One transfer: setup, then access held until ready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // Pin-synced gray frame: one blank line holding a pixel to drop, then the live line.
    task automatic gframe(input logic [31:0] c, input logic [11:0] p0, p1, input int n, input logic [31:0] x);
        apb(1, 8'h00, c);
        {sen.vpol, sen.hpol, sen.pol} = {c[4], c[3], c[2]};
        wq = {};
        sen.pulse(1);
        sen.pulse(0);
        sen.pix(12'h111);
        sen.pulse(0);
        sen.pix(p0);
        sen.pix(p1);
        #300;
        chk("gray count", 32'(wq.size()), 32'(n));
        chk("gray word", wq[0], x);
    endtask
    // Coded frame with the line pin held active, which must have no effect.
    task automatic eframe(input logic [31:0] c, input logic [7:0] b0, b1, b2, b3, input logic [31:0] x);
        apb(1, 8'h00, c);
        {sen.vpol, sen.hpol, sen.pol} = 3'b000;
        wq = {};
        sen.hs = 1;
        sen.code(8'hB6);
        sen.pix(12'h055);
        sen.code(8'h80);
        sen.pix({4'h0, b0});
        sen.pix({4'h0, b1});
        sen.pix({4'h0, b2});
        sen.pix({4'h0, b3});
        sen.code(8'h9D);
        sen.pix(12'h0AA);
        sen.hs = 0;
        #300;
        chk("coded count", 32'(wq.size()), 1);
        chk("coded word", wq[0], x);
    endtask
    task automatic test_done;
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence: reset values, unmapped access, then gray and coded frames.
    initial begin
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'b1;
        apb(0, 8'h00, 0);
        chk("ctrl reset", r, 32'h00000000);
        apb(0, 8'h0C, 0);
        chk("csc0 reset", r, 32'h1A0D3325);
        apb(0, 8'h10, 0);
        chk("csc1 reset", r, 32'h80801043);
        apb(1, 8'h1C, 32'hFFFFFFFF);
        chk("unmapped error", {31'h0, e}, 32'h1);
        apb(1, 8'h08, 32'h00000020);
        apb(0, 8'h08, 0);
        chk("decim readback", r, 32'h00000020);
        apb(1, 8'h08, 32'h00000010);
        apb(1, 8'h04, 32'h00000100);
        gframe(32'h3C01, 12'hABC, 12'hDEF, 2, 32'hABC00000);
        gframe(32'h2C1D, 12'h123, 12'h456, 1, 32'h12304560);
        eframe(32'h2803, 8'h8D, 8'h47, 8'h00, 8'h00, 32'h46A70000);
        eframe(32'h2903, 8'h51, 8'h3D, 8'h00, 8'h00, 32'h46A70000);
        eframe(32'h2A03, 8'hB1, 8'hE2, 8'h00, 8'h00, 32'h46A70000);
        // Unity, half and double gains with Cb and Cr 32 above and below mid-scale; the second pixel's blue clips high.
        apb(1, 8'h0C, 32'h10102020);
        apb(1, 8'h10, 32'h80801040);
        eframe(32'h2003, 8'hA0, 8'h90, 8'h60, 8'hF0, 32'h3218639F);
        eframe(32'h2043, 8'h90, 8'hA0, 8'hF0, 8'h60, 32'h3218639F);
        test_done;
    end
    // Watchdog well past the expected run length.
    initial begin
        #500000;
        err_total++;
        test_done;
    end
endmodule
